// >>> rtl/prom_loader_pkg.sv
// Constants and types shared by the serial PROM configuration loader.
package prom_loader_pkg;
   // Widths and the arbitration retry limit
   localparam int PROM_AW = 16;
   localparam int DW_IDX_W = 14;
   localparam int CNT_W = 16;
   localparam int BYTE_W = 8;
   localparam int WORD_W = 32;
   localparam int AV_AW = 5;
   localparam int ARB_CNT_W = 5;
   localparam int ERR_W = 5;
   localparam int ARB_RETRY_LIMIT = 16;
   // Block stream encoding
   localparam logic [1:0] TYPE_SINGLE = 2'h0;
   localparam logic [1:0] TYPE_SEQ = 2'h1;
   localparam logic [1:0] TYPE_BAD = 2'h2;
   localparam logic [1:0] TYPE_DONE = 2'h3;
   localparam int TYPE_MSB = 7;
   localparam int TYPE_LSB = 6;
   localparam int IDX_HI_MSB = 5;
   localparam logic [1:0] DATA_LAST = 2'h3;
   localparam logic [1:0] DW_PAD = 2'h0;
   localparam logic [7:0] SUM_OK = 8'hFF;
   localparam logic [7:0] SUM_INIT = 8'h00;
   localparam logic [PROM_AW-1:0] PROM_ADDR_START = 16'h0000;
   localparam logic [PROM_AW-1:0] PROM_ADDR_MAX = 16'hFFFF;
   localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
   localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
   // Register byte offsets
   localparam logic [AV_AW-1:0] OFS_CTL = 5'h00;
   localparam logic [AV_AW-1:0] OFS_STS = 5'h04;
   localparam logic [AV_AW-1:0] OFS_SWC = 5'h08;
   localparam logic [AV_AW-1:0] OFS_HOST = 5'h0C;
   // Field positions
   localparam int CTL_SKIP = 0;
   localparam int STS_UNMAPPED = 0;
   localparam int STS_FMT = 1;
   localparam int STS_NACK = 2;
   localparam int STS_LOST = 3;
   localparam int STS_OTHER = 4;
   localparam int SWC_HOLD = 0;
   localparam int HOST_ADDR_LSB = 8;
   localparam int HOST_DIR_BIT = 24;
   localparam logic [4:0] HOST_PAD = 5'h00;
   // Sequencer states and block field phases
   typedef enum logic [2:0] {ST_IDLE, ST_FETCH, ST_WAIT, ST_CHECK, ST_READY, ST_HOST} state_t;
   typedef enum logic [2:0] {PH_LO, PH_HI, PH_CNT0, PH_CNT1, PH_DATA} phase_t;
endpackage : prom_loader_pkg

// >>> rtl/bus_condition_monitor.sv
// START/STOP watcher on the sampled serial bus pins.
`timescale 1ns/1ps
`default_nettype none
module bus_condition_monitor (
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // Bus pins, asynchronous
   input wire logic scl_i,
   input wire logic sda_i,
   // Qualifiers from the same clock
   input wire logic watch_i,
   input wire logic expected_i,
   // Result
   output logic misplaced_o
);
   logic [1:0] scl_sync_q;
   logic [1:0] sda_sync_q;
   logic scl_q;
   logic sda_q;

   // Two flops per pin, then one more stage for edge finding
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         scl_sync_q <= 2'h3;
         sda_sync_q <= 2'h3;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_sync_q <= {scl_sync_q[0], scl_i};
         sda_sync_q <= {sda_sync_q[0], sda_i};
         scl_q <= scl_sync_q[1];
         sda_q <= sda_sync_q[1];
      end
   end

   // Data edge while clock stays high marks a bus condition
   wire scl_high = scl_q & scl_sync_q[1];
   wire start_seen = scl_high & sda_q & ~sda_sync_q[1];
   wire stop_seen = scl_high & ~sda_q & sda_sync_q[1];

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         misplaced_o <= 1'b0;
      end else begin
         misplaced_o <= (start_seen | stop_seen) & watch_i & ~expected_i;
      end
   end
endmodule : bus_condition_monitor
`default_nettype wire

// >>> rtl/serial_prom_config_loader.sv
// Serial PROM configuration loader with Avalon-MM register slave.
`timescale 1ns/1ps
`default_nettype none
module serial_prom_config_loader
   import prom_loader_pkg::*;
#(
   parameter int ARB_LIMIT = ARB_RETRY_LIMIT
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic reset_i,
   // Avalon-MM register slave
   input wire logic [AV_AW-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [WORD_W-1:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [WORD_W-1:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // Load strap, sampled once after reset
   input wire logic prom_load_en_i,
   // Byte engine request and answer
   output logic eng_req_o,
   output logic eng_write_o,
   output logic [PROM_AW-1:0] eng_addr_o,
   output logic [BYTE_W-1:0] eng_wdata_o,
   input wire logic eng_done_i,
   input wire logic [BYTE_W-1:0] eng_rdata_i,
   input wire logic eng_nack_i,
   input wire logic eng_arb_lost_i,
   input wire logic eng_cond_expected_i,
   // Observed bus pins
   input wire logic smb_scl_i,
   input wire logic smb_sda_i,
   // Configuration register write port
   output logic [PROM_AW-1:0] cfg_addr_o,
   output logic [WORD_W-1:0] cfg_data_o,
   output logic cfg_wr_o,
   input wire logic cfg_mapped_i,
   // Device status
   output logic reset_hold_o,
   output logic load_done_o
);
   state_t state_q;
   phase_t phase_q;
   logic [PROM_AW-1:0] prom_addr_q;
   logic [7:0] sum_q;
   logic [7:0] idx_lo_q;
   logic [DW_IDX_W-1:0] dword_idx_q;
   logic [CNT_W-1:0] dword_count_q;
   logic [1:0] byte_cnt_q;
   logic [WORD_W-1:0] data_q;
   logic [ARB_CNT_W-1:0] arb_cnt_q;
   logic host_busy_q;
   logic host_done_q;
   logic host_dir_q;
   logic [PROM_AW-1:0] host_addr_q;
   logic [BYTE_W-1:0] host_data_q;
   logic wait_q;
   logic skip_q;
   logic [ERR_W-1:0] err_q;
   logic misplaced;

   bus_condition_monitor u_cond (
      .clk_i(sys_clk_i),
      .reset_i(reset_i),
      .scl_i(smb_scl_i),
      .sda_i(smb_sda_i),
      .watch_i(eng_req_o),
      .expected_i(eng_cond_expected_i),
      .misplaced_o(misplaced)
   );

   // Event decode for the byte engine answer
   wire in_wait = state_q == ST_WAIT;
   wire in_host = state_q == ST_HOST;
   wire eng_wait = in_wait | in_host;
   wire [1:0] blk_type = eng_rdata_i[TYPE_MSB:TYPE_LSB];
   wire byte_ok = eng_wait & eng_done_i & ~eng_arb_lost_i & ~eng_nack_i;
   wire load_byte = in_wait & byte_ok & ~misplaced;
   wire is_hi = phase_q == PH_HI;
   wire done_seq = load_byte & is_hi & (blk_type == TYPE_DONE);
   wire [7:0] sum_d = sum_q + eng_rdata_i;
   wire sum_good = (sum_d == SUM_OK) | skip_q;
   wire roll_over = ~done_seq & (prom_addr_q == PROM_ADDR_MAX);
   wire bad_type = is_hi & (blk_type == TYPE_BAD);
   wire ev_fmt = load_byte & (bad_type | (done_seq & ~sum_good) | roll_over);
   wire ev_nack = eng_wait & eng_done_i & eng_nack_i & ~eng_arb_lost_i;
   wire arb_at_limit = arb_cnt_q == ARB_CNT_W'(ARB_LIMIT - 1);
   wire ev_lost = eng_wait & eng_done_i & eng_arb_lost_i & arb_at_limit;
   wire arb_retry = eng_done_i & eng_arb_lost_i & ~arb_at_limit;
   wire ev_other = eng_wait & misplaced;
   wire ev_unmapped = (state_q == ST_CHECK) & ~cfg_mapped_i;
   wire load_fail = in_wait & (ev_fmt | ev_nack | ev_lost | ev_other);
   wire load_ok = done_seq & sum_good;
   wire [CNT_W-1:0] count_new = {eng_rdata_i, dword_count_q[7:0]};
   wire [WORD_W-1:0] data_new = {eng_rdata_i, data_q[WORD_W-1:BYTE_W]};

   // Register slave decode
   wire wr_take = avs_write_i & ~wait_q;
   wire rd_grab = (avs_read_i | avs_write_i) & wait_q;
   wire sel_ctl = avs_address_i == OFS_CTL;
   wire sel_sts = avs_address_i == OFS_STS;
   wire sel_swc = avs_address_i == OFS_SWC;
   wire sel_host = avs_address_i == OFS_HOST;
   wire wr_lane0 = wr_take & avs_byteenable_i[0];
   wire wr_ctl = wr_lane0 & sel_ctl;
   wire wr_sts = wr_lane0 & sel_sts;
   wire wr_swc = wr_lane0 & sel_swc;
   wire wr_host = wr_take & sel_host;
   // Loader owns the bus until it is ready, so host sees busy
   wire busy_view = host_busy_q | (state_q != ST_READY);
   wire host_start = wr_host & avs_byteenable_i[0] & ~busy_view;
   wire [BYTE_W-1:0] host_alo_new = (wr_host & avs_byteenable_i[1]) ?
      avs_writedata_i[HOST_ADDR_LSB +: BYTE_W] : host_addr_q[BYTE_W-1:0];
   wire [BYTE_W-1:0] host_ahi_new = (wr_host & avs_byteenable_i[2]) ?
      avs_writedata_i[HOST_ADDR_LSB + BYTE_W +: BYTE_W] : host_addr_q[PROM_AW-1:BYTE_W];
   wire host_dir_new = (wr_host & avs_byteenable_i[3]) ?
      avs_writedata_i[HOST_DIR_BIT] : host_dir_q;
   wire [ERR_W-1:0] err_set = {ev_other, ev_lost, ev_nack, ev_fmt, ev_unmapped};
   wire [ERR_W-1:0] err_clr = wr_sts ? avs_writedata_i[ERR_W-1:0] : {ERR_W{1'b0}};
   wire [WORD_W-1:0] rd_ctl = WORD_W'(skip_q);
   wire [WORD_W-1:0] rd_sts = WORD_W'({load_done_o, err_q});
   wire [WORD_W-1:0] rd_swc = WORD_W'(reset_hold_o);
   wire [WORD_W-1:0] rd_host = {host_done_q, busy_view, HOST_PAD, host_dir_q, host_addr_q,
      host_data_q};
   wire [WORD_W-1:0] rd_mux = sel_ctl ? rd_ctl : sel_sts ? rd_sts : sel_swc ? rd_swc :
      sel_host ? rd_host : {WORD_W{1'b0}};

   // Slave handshake and software registers; hardware set wins over clear
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         wait_q <= 1'b1;
         avs_readdata_o <= {WORD_W{1'b0}};
         skip_q <= 1'b0;
         err_q <= {ERR_W{1'b0}};
         reset_hold_o <= 1'b0;
         load_done_o <= 1'b0;
      end else begin
         wait_q <= ~rd_grab;
         if (rd_grab) begin
            avs_readdata_o <= rd_mux;
         end
         if (wr_ctl) begin
            skip_q <= avs_writedata_i[CTL_SKIP];
         end
         err_q <= (err_q & ~err_clr) | err_set;
         reset_hold_o <= (wr_swc ? avs_writedata_i[SWC_HOLD] : reset_hold_o) | load_fail;
         load_done_o <= load_done_o | load_fail | load_ok;
      end
   end
   assign avs_waitrequest_o = wait_q;

   // Load and host access sequencer
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         state_q <= ST_IDLE;
         phase_q <= PH_LO;
         prom_addr_q <= PROM_ADDR_START;
         sum_q <= SUM_INIT;
         idx_lo_q <= 8'h00;
         dword_idx_q <= {DW_IDX_W{1'b0}};
         dword_count_q <= CNT_ZERO;
         byte_cnt_q <= 2'h0;
         data_q <= {WORD_W{1'b0}};
         arb_cnt_q <= {ARB_CNT_W{1'b0}};
         cfg_addr_o <= {PROM_AW{1'b0}};
         cfg_data_o <= {WORD_W{1'b0}};
         cfg_wr_o <= 1'b0;
         eng_req_o <= 1'b0;
         eng_write_o <= 1'b0;
         eng_addr_o <= {PROM_AW{1'b0}};
         eng_wdata_o <= {BYTE_W{1'b0}};
         host_busy_q <= 1'b0;
         host_done_q <= 1'b0;
         host_dir_q <= 1'b0;
         host_addr_q <= {PROM_AW{1'b0}};
         host_data_q <= {BYTE_W{1'b0}};
      end else begin
         cfg_wr_o <= 1'b0;
         host_addr_q <= {host_ahi_new, host_alo_new};
         host_dir_q <= host_dir_new;
         if (wr_host & avs_byteenable_i[0] & ~busy_view) begin
            host_data_q <= avs_writedata_i[BYTE_W-1:0];
         end
         case (state_q)
            ST_IDLE: begin
               // Strap taken on the first edge after release
               state_q <= prom_load_en_i ? ST_FETCH : ST_READY;
            end
            ST_FETCH: begin
               eng_req_o <= 1'b1;
               eng_write_o <= 1'b0;
               eng_addr_o <= prom_addr_q;
               state_q <= ST_WAIT;
            end
            ST_WAIT: begin
               if (load_fail) begin
                  eng_req_o <= 1'b0;
                  state_q <= ST_READY;
               end else if (eng_done_i & eng_arb_lost_i) begin
                  arb_cnt_q <= arb_cnt_q + 1'b1; // Request stays up for a retry
               end else if (load_byte) begin
                  eng_req_o <= 1'b0;
                  arb_cnt_q <= {ARB_CNT_W{1'b0}};
                  sum_q <= sum_d;
                  prom_addr_q <= prom_addr_q + 1'b1;
                  state_q <= ST_FETCH;
                  case (phase_q)
                     PH_LO: begin
                        idx_lo_q <= eng_rdata_i;
                        phase_q <= PH_HI;
                     end
                     PH_HI: begin
                        dword_idx_q <= {eng_rdata_i[IDX_HI_MSB:0], idx_lo_q};
                        dword_count_q <= CNT_ONE;
                        phase_q <= (blk_type == TYPE_SEQ) ? PH_CNT0 : PH_DATA;
                        if (done_seq) begin
                           state_q <= ST_READY;
                        end
                     end
                     PH_CNT0: begin
                        dword_count_q <= {CNT_ZERO[CNT_W-1:BYTE_W], eng_rdata_i};
                        phase_q <= PH_CNT1;
                     end
                     PH_CNT1: begin
                        dword_count_q <= count_new;
                        // Empty sequential block: next byte opens a new one
                        phase_q <= (count_new == CNT_ZERO) ? PH_LO : PH_DATA;
                     end
                     PH_DATA: begin
                        data_q <= data_new;
                        byte_cnt_q <= byte_cnt_q + 1'b1;
                        if (byte_cnt_q == DATA_LAST) begin
                           cfg_addr_o <= {dword_idx_q, DW_PAD};
                           cfg_data_o <= data_new;
                           state_q <= ST_CHECK;
                        end
                     end
                     default: phase_q <= PH_LO;
                  endcase
               end
            end
            ST_CHECK: begin
               cfg_wr_o <= cfg_mapped_i;
               dword_idx_q <= dword_idx_q + 1'b1;
               dword_count_q <= dword_count_q - 1'b1;
               phase_q <= (dword_count_q == CNT_ONE) ? PH_LO : PH_DATA;
               state_q <= ST_FETCH;
            end
            ST_READY: begin
               if (host_start) begin
                  host_busy_q <= 1'b1;
                  host_done_q <= 1'b0;
                  eng_req_o <= 1'b1;
                  eng_write_o <= host_dir_new;
                  eng_addr_o <= {host_ahi_new, host_alo_new};
                  eng_wdata_o <= avs_writedata_i[BYTE_W-1:0];
                  state_q <= ST_HOST;
               end
            end
            ST_HOST: begin
               if (arb_retry) begin
                  arb_cnt_q <= arb_cnt_q + 1'b1;
               end else if (eng_done_i) begin
                  eng_req_o <= 1'b0;
                  arb_cnt_q <= {ARB_CNT_W{1'b0}};
                  host_busy_q <= 1'b0;
                  host_done_q <= 1'b1;
                  if (byte_ok & ~eng_write_o) begin
                     host_data_q <= eng_rdata_i;
                  end
                  state_q <= ST_READY;
               end
            end
            default: state_q <= ST_READY;
         endcase
      end
   end

   // Checks on the sequencer
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (reset_i);

   sequence s_aborted;
      reset_hold_o && load_done_o && (state_q == ST_READY) && !eng_req_o;
   endsequence

   abort_holds_a: assert property (load_fail |=> s_aborted)
      else $error("load error did not halt the loader");
   fmt_flag_a: assert property (ev_fmt |=> err_q[STS_FMT] && reset_hold_o)
      else $error("format error not recorded");
   done_flag_a: assert property ((load_fail || load_ok) |=> load_done_o)
      else $error("load complete flag missing");
   sum_track_a: assert property ((load_byte && !load_fail) |=>
      sum_q == $past(sum_q) + $past(eng_rdata_i))
      else $error("running sum wrong");
   byte_addr_a: assert property (cfg_wr_o |-> cfg_addr_o == {$past(dword_idx_q), DW_PAD})
      else $error("register byte address wrong");
   index_step_a: assert property ((state_q == ST_CHECK) |=>
      dword_idx_q == DW_IDX_W'($past(dword_idx_q) + 1'b1))
      else $error("dword index did not advance");
   unmapped_drop_a: assert property (ev_unmapped |=> !cfg_wr_o && err_q[STS_UNMAPPED])
      else $error("unmapped write not dropped");
   skip_check_a: assert property ((done_seq && skip_q) |=>
      load_done_o && !reset_hold_o && state_q == ST_READY)
      else $error("skip check still aborted");
   arb_retry_a: assert property ((in_wait && arb_retry && !misplaced) |=>
      eng_req_o && arb_cnt_q == $past(arb_cnt_q) + 1'b1)
      else $error("arbitration retry not counted");
   host_done_a: assert property ((in_host && eng_done_i && !arb_retry) |=>
      host_done_q && !host_busy_q && state_q == ST_READY)
      else $error("host access did not complete");
endmodule : serial_prom_config_loader
`default_nettype wire

// >>> sim/prom_engine_model.sv
// Behavioural byte engine with a small serial PROM behind it.
`timescale 1ns/1ps
`default_nettype none
module prom_engine_model (
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // Request from the loader
   input wire logic req_i,
   input wire logic write_i,
   input wire logic [15:0] addr_i,
   input wire logic [7:0] wdata_i,
   // Fault injection from the bench
   input wire logic [15:0] nack_addr_i,
   input wire logic [3:0] arb_fails_i,
   input wire logic stray_i,
   // Answer to the loader
   output logic done_o,
   output logic [7:0] rdata_o,
   output logic nack_o,
   output logic arb_lost_o,
   // Bus pins
   output logic scl_o,
   output logic sda_o
);
   logic [7:0] mem [0:255];
   int wait_c;
   int lost_c;
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   // Link clock only runs inside transfers; data line rests at its pull-up level
   always begin
      #24;
      // A stray data pulse needs the clock parked high to count as START and STOP
      scl_o = (req_i && !stray_i) ? ~scl_o : 1'b1;
   end
   // Odd addresses answer slowly, even ones promptly
   always @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         done_o <= 1'b0;
         nack_o <= 1'b0;
         arb_lost_o <= 1'b0;
         rdata_o <= 8'h00;
         wait_c <= 0;
         lost_c <= 0;
         sda_o <= 1'b1;
      end else begin
         done_o <= 1'b0;
         // One-clock low pulse in the middle of a slow read
         sda_o <= !(stray_i && req_i && !done_o && wait_c == 2);
         nack_o <= 1'b0;
         arb_lost_o <= 1'b0;
         rdata_o <= ~rdata_o; // Read data not valid outside done
         if (req_i && !done_o) begin
            wait_c <= wait_c + 1;
            if (wait_c >= (addr_i[0] ? 6 : 1)) begin
               wait_c <= 0;
               done_o <= 1'b1;
               if (lost_c < arb_fails_i) begin
                  arb_lost_o <= 1'b1; // Injected lost arbitration
                  lost_c <= lost_c + 1;
               end else if (addr_i == nack_addr_i) begin
                  nack_o <= 1'b1; // Injected missing acknowledge
               end else if (write_i) begin
                  mem[addr_i[7:0]] <= wdata_i;
               end else begin
                  rdata_o <= (addr_i[15:8] != 8'h00) ? 8'hFF : mem[addr_i[7:0]];
               end
            end
         end
      end
   end
endmodule : prom_engine_model
`default_nettype wire

// >>> sim/serial_prom_config_loader_tb.sv
// Self-checking bench for the serial PROM configuration loader.
`timescale 1ns/1ps
`default_nettype none
module serial_prom_config_loader_tb;
   import prom_loader_pkg::*;
   logic sys_clk_i = 1'b0, reset_i = 1'b1, avs_read_i = 1'b0, avs_write_i = 1'b0;
   logic [4:0] avs_address_i = 5'h00;
   logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, q;
   logic [3:0] avs_byteenable_i = 4'hF;
   logic avs_waitrequest_o, eng_req_o, eng_write_o, eng_done_i, eng_nack_i, eng_arb_lost_i;
   logic [15:0] eng_addr_o, cfg_addr_o, nack_addr = 16'hFFFF;
   logic [7:0] eng_wdata_o, eng_rdata_i, sum;
   logic [3:0] arb_fails = 4'h0;
   logic stray = 1'b0;
   logic scl, sda, cfg_wr_o, reset_hold_o, load_done_o;
   logic [31:0] cfg_data_o;
   logic [15:0] cap_a[$];
   logic [31:0] cap_d[$];
   logic [7:0] img[$];
   int n_fail = 0, n_compared = 0;
   always #2.5 sys_clk_i = ~sys_clk_i;
   wire cfg_mapped = (cfg_addr_o !== 16'hFFFC); // Top dword treated as undefined
   serial_prom_config_loader #(.ARB_LIMIT(3)) dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
      .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
      .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
      .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
      .prom_load_en_i(1'b1), .eng_req_o(eng_req_o), .eng_write_o(eng_write_o),
      .eng_addr_o(eng_addr_o), .eng_wdata_o(eng_wdata_o), .eng_done_i(eng_done_i),
      .eng_rdata_i(eng_rdata_i), .eng_nack_i(eng_nack_i), .eng_arb_lost_i(eng_arb_lost_i),
      .eng_cond_expected_i(1'b0), .smb_scl_i(scl), .smb_sda_i(sda), .cfg_addr_o(cfg_addr_o),
      .cfg_data_o(cfg_data_o), .cfg_wr_o(cfg_wr_o), .cfg_mapped_i(cfg_mapped),
      .reset_hold_o(reset_hold_o), .load_done_o(load_done_o));
   prom_engine_model pm (.clk_i(sys_clk_i), .reset_i(reset_i), .req_i(eng_req_o),
      .write_i(eng_write_o), .addr_i(eng_addr_o), .wdata_i(eng_wdata_o),
      .nack_addr_i(nack_addr), .arb_fails_i(arb_fails), .stray_i(stray), .done_o(eng_done_i),
      .rdata_o(eng_rdata_i), .nack_o(eng_nack_i), .arb_lost_o(eng_arb_lost_i),
      .scl_o(scl), .sda_o(sda));
   // Record every register write the loader issues
   always @(posedge sys_clk_i) begin
      if (cfg_wr_o === 1'b1) begin
         cap_a.push_back(cfg_addr_o);
         cap_d.push_back(cfg_data_o);
      end
   end
   task automatic print_verdict();
      if (n_fail == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : print_verdict
   task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask : cmp
   // One Avalon transfer, held until waitrequest is sampled low
   task automatic av(input logic wr, input logic [4:0] a, input logic [31:0] d,
                     input logic [3:0] be);
      int k;
      @(posedge sys_clk_i);
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_byteenable_i <= be;
      avs_read_i <= ~wr;
      avs_write_i <= wr;
      for (k = 0; k < 50; k++) begin
         @(posedge sys_clk_i);
         if (avs_waitrequest_o === 1'b0) break;
      end
      q = avs_readdata_o;
      avs_read_i <= 1'b0;
      avs_write_i <= 1'b0;
      if (k == 50) begin
         n_fail++;
         print_verdict();
      end
   endtask : av
   // Lay out the image, close it with a done sequence and run a load
   task automatic load(input logic [7:0] bad, input logic skip);
      int k;
      sum = 8'hC0;
      for (k = 0; k < 256; k++) pm.mem[k] = 8'hFF;
      foreach (img[i]) begin
         pm.mem[i] = img[i];
         sum = sum + img[i];
      end
      pm.mem[img.size()] = ~sum ^ bad; // Ones' complement of the byte sum
      pm.mem[img.size() + 1] = 8'hC0; // Done type in upper bits
      cap_a.delete();
      cap_d.delete();
      reset_i <= 1'b1;
      repeat (20) @(posedge sys_clk_i);
      reset_i <= 1'b0;
      // Control is cleared by reset, so the skip bit goes in while the load runs
      if (skip) av(1'b1, OFS_CTL, 32'h1, 4'hF);
      for (k = 0; k < 20000 && load_done_o !== 1'b1; k++) @(posedge sys_clk_i);
      if (k == 20000) begin
         n_fail++;
         print_verdict();
      end
   endtask : load
   // Error images and the status each must leave
   logic [7:0] bad_v[6] = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00};
   logic [31:0] sts_v[6] = '{32'h22, 32'h22, 32'h24, 32'h28, 32'h20, 32'h30};
   initial begin
      // Single, sequential of two words, then one unmapped single
      img = '{8'h10, 8'h00, 8'h11, 8'h22, 8'h33, 8'h44, 8'h20, 8'h40, 8'h02, 8'h00,
              8'hAA, 8'hBB, 8'hCC, 8'hDD, 8'h01, 8'h02, 8'h03, 8'h04,
              8'hFF, 8'h3F, 8'h55, 8'h55, 8'h55, 8'h55};
      load(8'h00, 1'b0);
      cmp("writes", 3, cap_a.size());
      cmp("addr0", 32'h40, cap_a[0]);
      cmp("data0", 32'h44332211, cap_d[0]);
      cmp("addr1", 32'h80, cap_a[1]);
      cmp("data1", 32'hDDCCBBAA, cap_d[1]);
      cmp("addr2", 32'h84, cap_a[2]);
      cmp("data2", 32'h04030201, cap_d[2]);
      cmp("hold", 0, reset_hold_o);
      av(1'b0, OFS_STS, 32'h0, 4'hF);
      cmp("status", 32'h21, q & 32'h3F);
      av(1'b0, 5'h10, 32'h0, 4'hF);
      cmp("unmapped read", 32'h0, q);
      av(1'b1, OFS_CTL, 32'h1, 4'hF);
      av(1'b0, OFS_CTL, 32'h0, 4'hF);
      cmp("control", 32'h1, q & 32'h1);
      // Host write of one byte, then read it back
      av(1'b1, OFS_HOST, 32'h0100_0500, 4'hE);
      av(1'b0, OFS_HOST, 32'h0, 4'hF);
      cmp("host idle", 32'h0, q & 32'h4000_0000);
      av(1'b1, OFS_HOST, 32'h0000_00AB, 4'h1);
      for (int k = 0; k < 100; k++) begin
         av(1'b0, OFS_HOST, 32'h0, 4'hF);
         if (q[31] === 1'b1) break;
      end
      cmp("host wr done", 32'h8000_0000, q & 32'hC000_0000);
      cmp("prom byte", 32'hAB, pm.mem[5]);
      av(1'b1, OFS_HOST, 32'h0000_0500, 4'hE);
      av(1'b0, OFS_HOST, 32'h0, 4'hF);
      cmp("host idle", 32'h0, q & 32'h4000_0000);
      av(1'b1, OFS_HOST, 32'h0000_0000, 4'h1);
      for (int k = 0; k < 100; k++) begin
         av(1'b0, OFS_HOST, 32'h0, 4'hF);
         if (q[31] === 1'b1) break;
      end
      cmp("host rd data", 32'h8000_00AB, q & 32'hC000_00FF);
      // Host read that draws a missing acknowledge: flagged, but no halt
      av(1'b1, OFS_HOST, 32'h00FF_FF00, 4'hE);
      av(1'b1, OFS_HOST, 32'h0000_0000, 4'h1);
      for (int k = 0; k < 100; k++) begin
         av(1'b0, OFS_HOST, 32'h0, 4'hF);
         if (q[31] === 1'b1) break;
      end
      av(1'b0, OFS_STS, 32'h0, 4'hF);
      cmp("host error", 32'h25, q & 32'h3F);
      cmp("host hold", 0, reset_hold_o);
      // Bad checksum, bad type, missing acknowledge, lost arbitration,
      // bad checksum with checking skipped, stray bus condition
      for (int e = 0; e < 6; e++) begin
         if (e == 1) img = '{8'h00, 8'h80};
         else img = '{8'h10, 8'h00, 8'h11, 8'h22, 8'h33, 8'h44};
         nack_addr <= (e == 2) ? 16'h0002 : 16'hFFFF;
         arb_fails <= (e == 3) ? 4'h3 : 4'h0;
         stray <= (e == 5);
         load(bad_v[e], e == 4);
         av(1'b0, OFS_STS, 32'h0, 4'hF);
         cmp("error status", sts_v[e], q & 32'h3F);
         av(1'b0, OFS_SWC, 32'h0, 4'hF);
         cmp("reset hold", e != 4, q & 32'h1);
         cmp("hold pin", e != 4, reset_hold_o);
         cmp("stopped", 0, eng_req_o);
      end
      print_verdict();
   end
endmodule : serial_prom_config_loader_tb
`default_nettype wire
